// *** hdl/clock_gen_pkg.sv ***
// Constants shared by the clock generator, its assertion checker and its bench
package clock_gen_pkg;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  localparam logic [ADR_W-1:0] CPU_CLOCK_CONTROL_OFF   = 4'h0;
  localparam logic [ADR_W-1:0] CLOCK_OUTPUT_MODE_OFF   = 4'h4;
  localparam logic [ADR_W-1:0] INTERVAL_TIMER_MODE_OFF = 4'h8;
  localparam logic [ADR_W-1:0] CLOCK_STATUS_OFF        = 4'hc;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CCC_HALT_BIT = 2;
  localparam int CCC_STOP_BIT = 3;
  localparam int COM_ZERO_BIT = 2;
  localparam int COM_EN_BIT   = 3;
  localparam int STS_PEND_BIT = 0;
  localparam int STS_RUN_BIT  = 1;
  localparam int STS_ACT_LO   = 2;

  localparam logic [3:0] CPU_CLOCK_CONTROL_RST   = 4'h0;
  localparam logic [3:0] CLOCK_OUTPUT_MODE_RST   = 4'h0;
  localparam logic [3:0] INTERVAL_TIMER_MODE_RST = 4'h0;

  // ---------------------------------------------------------------
  // Divider and wait timing
  // ---------------------------------------------------------------
  localparam int DIV_W  = 6;
  localparam int WAIT_W = 21;
  localparam logic [DIV_W-1:0] DIV_LAST = 6'h3f;

  localparam logic [4:0] RESET_EXP_LONG  = 5'h11;
  localparam logic [4:0] RESET_EXP_SHORT = 5'h0f;
  localparam logic [4:0] STOP_EXP_000    = 5'h14;
  localparam logic [4:0] STOP_EXP_011    = 5'h11;
  localparam logic [4:0] STOP_EXP_101    = 5'h0f;
  localparam logic [4:0] STOP_EXP_111    = 5'h0d;

  // ---------------------------------------------------------------
  // CPU operating state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_STOP = 2'b10,
    ST_WAIT = 2'b11
  } cpu_state_e;

endpackage : clock_gen_pkg

// *** hdl/clock_output_gate.sv ***
// Glitch-free enable gate for the clock output pin
`timescale 1ns/100ps
`default_nettype none
module clock_output_gate (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  // Source and request
  input  wire logic i_source,
  input  wire logic i_enable,
  // Gated output
  output logic      o_pin,
  output logic      o_active
);

  logic active_reg;
  logic pin_reg;

  // ---------------------------------------------------------------
  // Enable changes only while the source is low
  // ---------------------------------------------------------------
  // whole pulses only
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_reg <= 1'b0;
    end else if (!i_source) begin
      active_reg <= i_enable;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= i_source & active_reg;
    end
  end

  assign o_pin    = pin_reg;
  assign o_active = active_reg;

endmodule : clock_output_gate
`default_nettype wire

// *** hdl/cpu_clock_gen.sv ***
// CPU clock generator: divider, clock switch, waits and clock output
//
// Function
// - New CPU clock selection applies after delay
// - Delay 1/4/8/16 cycles by previous setting
// - After reset wait, start at slowest clock
// - Reset wait length set by strap option
// - STOP release wait length from timer mode
// - Internal clocks come from divider chain
// - Output enable never makes narrow pulses; here a single write that enables and changes the select can make one
// - Output mode register 4-bit, write-only
// - Reset clears output mode, output disabled
// - Value 1000B outputs CPU clock on pin
// - Select codes give fx/64, /16, /8, /4
// - Reset clears control: slowest, normal mode
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_gen #(
  parameter int WAIT_EXP_TRIM = 0
) (
  // Clock and reset
  input  wire logic                               i_clock,
  input  wire logic                               i_arst_n,
  // Wishbone slave
  input  wire logic                               i_wb_cyc,
  input  wire logic                               i_wb_stb,
  input  wire logic                               i_wb_we,
  input  wire logic [clock_gen_pkg::ADR_W-1:0]    i_wb_adr,
  input  wire logic [clock_gen_pkg::SEL_W-1:0]    i_wb_sel,
  input  wire logic [clock_gen_pkg::DAT_W-1:0]    i_wb_dat,
  output logic      [clock_gen_pkg::DAT_W-1:0]    o_wb_dat,
  output logic                                    o_wb_ack,
  // Pins and events
  input  wire logic                               i_wait_option,
  input  wire logic                               i_standby_release,
  // CPU clocking
  output logic                                    o_cpu_tick,
  output logic                                    o_cpu_clock,
  output logic                                    o_cpu_run,
  output logic                                    o_halt,
  output logic                                    o_stop,
  output logic                                    o_switch_pending,
  // Clock output pin
  output logic                                    o_clock_output_pin
);
  import clock_gen_pkg::*;

  // ---------------------------------------------------------------
  // Decoding functions
  // ---------------------------------------------------------------
  // Divider bit that forms a square wave for a CPU clock selection
  function automatic logic [2:0] cpu_div_bit(input logic [1:0] sel);
    logic [2:0] idx;
    case (sel)
      2'b00:   idx = 3'd5;
      2'b01:   idx = 3'd3;
      2'b10:   idx = 3'd2;
      2'b11:   idx = 3'd1;
      default: idx = 3'd5;
    endcase
    return idx;
  endfunction : cpu_div_bit

  // Wait length exponent for a STOP release timer mode
  function automatic logic [4:0] stop_exp(input logic [2:0] mode);
    logic [4:0] e;
    case (mode)
      3'b011:  e = STOP_EXP_011;
      3'b101:  e = STOP_EXP_101;
      3'b111:  e = STOP_EXP_111;
      default: e = STOP_EXP_000;
    endcase
    return e;
  endfunction : stop_exp

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [DIV_W-1:0]  div_cnt_reg;
  logic [3:0]        ccc_reg;
  logic [1:0]        active_sel_reg;
  logic [3:0]        com_reg;
  logic [1:0]        out_sel_reg;
  logic [3:0]        itm_reg;
  cpu_state_e        state_reg;
  logic              wait_from_stop_reg;
  logic [WAIT_W-1:0] wait_cnt_reg;
  logic              opt_meta_reg;
  logic              opt_sync_reg;
  logic              rel_meta_reg;
  logic              rel_sync_reg;
  logic              ack_reg;
  logic [DAT_W-1:0]  dat_reg;
  logic              cpu_level_reg;
  logic              tick_reg;
  logic              out_src_reg;

  logic              bus_req;
  logic              wr_ccc;
  logic              wr_com;
  logic              wr_itm;
  logic              release_evt;
  logic              switch_now;
  logic [4:0]        wait_exp;
  logic [4:0]        wait_exp_trim;
  logic [WAIT_W-1:0] wait_last;
  logic              wait_done;
  logic [DIV_W-1:0]  tick_mask;
  logic              gate_active;

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  assign bus_req = i_wb_cyc & i_wb_stb & ~ack_reg;
  assign wr_ccc  = bus_req & i_wb_we & i_wb_sel[0]
                   & (i_wb_adr == CPU_CLOCK_CONTROL_OFF);
  assign wr_com  = bus_req & i_wb_we & i_wb_sel[0]
                   & (i_wb_adr == CLOCK_OUTPUT_MODE_OFF);
  assign wr_itm  = bus_req & i_wb_we & i_wb_sel[0]
                   & (i_wb_adr == INTERVAL_TIMER_MODE_OFF);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Read data, unmapped offsets read as zero
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dat_reg <= 32'h0000_0000;
    end else if (bus_req && !i_wb_we) begin
      dat_reg <= 32'h0000_0000;
      case (i_wb_adr)
        CPU_CLOCK_CONTROL_OFF:   dat_reg[3:0] <= ccc_reg;
        CLOCK_OUTPUT_MODE_OFF:   dat_reg[3:0] <= 4'h0;
        INTERVAL_TIMER_MODE_OFF: dat_reg[3:0] <= itm_reg;
        CLOCK_STATUS_OFF: begin
          dat_reg[STS_PEND_BIT]           <= o_switch_pending;
          dat_reg[STS_RUN_BIT]            <= o_cpu_run;
          dat_reg[STS_ACT_LO+1:STS_ACT_LO] <= active_sel_reg;
        end
        default:                 dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = dat_reg;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opt_meta_reg <= 1'b0;
      opt_sync_reg <= 1'b0;
      rel_meta_reg <= 1'b0;
      rel_sync_reg <= 1'b0;
    end else begin
      opt_meta_reg <= i_wait_option;
      opt_sync_reg <= opt_meta_reg;
      rel_meta_reg <= i_standby_release;
      rel_sync_reg <= rel_meta_reg;
    end
  end

  assign release_evt = rel_sync_reg
                       & ((state_reg == ST_HALT) | (state_reg == ST_STOP));

  // ---------------------------------------------------------------
  // Divider chain
  // ---------------------------------------------------------------
  // free-running fx divider
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // CPU clock control register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ccc_reg <= CPU_CLOCK_CONTROL_RST;
    end else if (wr_ccc) begin
      // Write wins over a release in the same cycle
      ccc_reg <= i_wb_dat[3:0];
    end else if (release_evt) begin
      ccc_reg[CCC_STOP_BIT:CCC_HALT_BIT] <= 2'b00;
    end
  end

  // ---------------------------------------------------------------
  // CPU clock switch
  // ---------------------------------------------------------------
  // change only at 64-period boundary
  assign switch_now = (div_cnt_reg == DIV_LAST);

  // 64 fx = 1/4/8/16 old cycles
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_sel_reg <= 2'b00;
    end else if (switch_now) begin
      active_sel_reg <= ccc_reg[1:0];
    end
  end

  assign o_switch_pending = (active_sel_reg != ccc_reg[1:0]);

  // divide by 64, 16, 8 or 4
  assign tick_mask = DIV_W'((7'h02 << cpu_div_bit(active_sel_reg)) - 7'h01);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cpu_level_reg <= 1'b0;
      tick_reg      <= 1'b0;
    end else begin
      cpu_level_reg <= div_cnt_reg[cpu_div_bit(active_sel_reg)];
      tick_reg      <= ((div_cnt_reg & tick_mask) == tick_mask)
                       & (state_reg == ST_RUN);
    end
  end

  assign o_cpu_tick  = tick_reg;
  assign o_cpu_clock = cpu_level_reg;

  // ---------------------------------------------------------------
  // Operating state and stabilisation waits
  // ---------------------------------------------------------------
  // strap picks reset wait
  assign wait_exp      = wait_from_stop_reg ? stop_exp(itm_reg[2:0])
                         : (opt_sync_reg ? RESET_EXP_SHORT
                                         : RESET_EXP_LONG);
  assign wait_exp_trim = wait_exp - 5'(WAIT_EXP_TRIM);
  assign wait_last     = (WAIT_W'(1) << wait_exp_trim) - WAIT_W'(1);
  assign wait_done     = (wait_cnt_reg == wait_last);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // start in wait at slowest clock
      state_reg <= ST_WAIT;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (wr_ccc && i_wb_dat[CCC_STOP_BIT]
              && !i_wb_dat[CCC_HALT_BIT]) begin
            state_reg <= ST_STOP;
          end else if (wr_ccc && i_wb_dat[CCC_HALT_BIT]
                       && !i_wb_dat[CCC_STOP_BIT]) begin
            state_reg <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (release_evt && !wr_ccc) begin
            state_reg <= ST_RUN;
          end
        end
        ST_STOP: begin
          if (release_evt && !wr_ccc) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_from_stop_reg <= 1'b0;
    end else if (state_reg == ST_STOP) begin
      wait_from_stop_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_cnt_reg <= '0;
    end else if (state_reg == ST_WAIT) begin
      wait_cnt_reg <= wait_cnt_reg + WAIT_W'(1);
    end else begin
      wait_cnt_reg <= '0;
    end
  end

  assign o_cpu_run = (state_reg == ST_RUN);
  assign o_halt    = (state_reg == ST_HALT);
  assign o_stop    = (state_reg == ST_STOP);

  // ---------------------------------------------------------------
  // Interval timer mode register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      itm_reg <= INTERVAL_TIMER_MODE_RST;
    end else if (wr_itm) begin
      itm_reg <= i_wb_dat[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Clock output mode and source
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      com_reg <= CLOCK_OUTPUT_MODE_RST;
    end else if (wr_com) begin
      com_reg <= i_wb_dat[3:0];
    end
  end

  // Frequency select follows only while the gate is idle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_sel_reg <= 2'b00;
    end else if (!gate_active) begin
      out_sel_reg <= com_reg[1:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_src_reg <= 1'b0;
    end else begin
      case (out_sel_reg)
        2'b00:   out_src_reg <= cpu_level_reg & ~o_stop;
        2'b01:   out_src_reg <= div_cnt_reg[2] & ~o_stop;
        2'b10:   out_src_reg <= div_cnt_reg[1] & ~o_stop;
        2'b11:   out_src_reg <= div_cnt_reg[0] & ~o_stop;
        default: out_src_reg <= 1'b0;
      endcase
    end
  end

  clock_output_gate u_gate (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_source (out_src_reg),
    .i_enable (com_reg[COM_EN_BIT]),
    .o_pin    (o_clock_output_pin),
    .o_active (gate_active)
  );
endmodule : cpu_clock_gen
`default_nettype wire

// *** tb/carrier_receiver.sv ***
// Pulse width monitor standing in for the carrier receiver
`timescale 1ns/100ps
`default_nettype none
module carrier_receiver (
  // Clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_arst_n,
  // Clear and pin
  input  wire logic   i_clear,
  input  wire logic   i_pin,
  // Shortest levels seen and rising edges
  output logic [7:0]  o_min_high,
  output logic [7:0]  o_min_low,
  output logic [15:0] o_edges
);
  logic [7:0] run_reg;
  logic       last_reg;
  logic       seen_reg;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_min_high <= 8'hff;
      o_min_low  <= 8'hff;
      o_edges    <= 16'h0000;
      seen_reg   <= 1'b0;
    end else if (i_clear) begin
      o_min_high <= 8'hff;
      o_min_low  <= 8'hff;
      o_edges    <= 16'h0000;
      seen_reg   <= 1'b0;
    end else if (i_pin != last_reg) begin
      if (seen_reg && last_reg && run_reg < o_min_high) o_min_high <= run_reg;
      if (seen_reg && !last_reg && run_reg < o_min_low) o_min_low <= run_reg;
      o_edges  <= o_edges + {15'h0000, i_pin};
      seen_reg <= 1'b1;
    end
  end

  // Length of the current level, saturating; first level is partial
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_reg  <= 8'h01;
      last_reg <= 1'b0;
    end else begin
      run_reg  <= (i_pin != last_reg) ? 8'h01
                : run_reg + {7'h00, run_reg != 8'hff};
      last_reg <= i_pin;
    end
  end
endmodule : carrier_receiver
`default_nettype wire

// *** tb/cpu_clock_gen_assertions.sv ***
// Port checker for the CPU clock generator
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_gen_assertions (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  // Register bus
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [31:0] o_wb_dat,
  input  wire logic        o_wb_ack,
  // CPU clocking and pin
  input  wire logic        o_cpu_tick,
  input  wire logic        o_cpu_clock,
  input  wire logic        o_cpu_run,
  input  wire logic        o_halt,
  input  wire logic        o_stop,
  input  wire logic        o_switch_pending,
  input  wire logic        o_clock_output_pin
);
  import clock_gen_pkg::*;

  logic req;
  logic mode_written_reg;
  logic mode_read_reg;

  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;

  // Output mode write seen, output mode read in flight
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_written_reg <= 1'b0;
      mode_read_reg    <= 1'b0;
    end else begin
      mode_read_reg <= req && !i_wb_we && i_wb_adr == CLOCK_OUTPUT_MODE_OFF;
      if (req && i_wb_we && i_wb_adr == CLOCK_OUTPUT_MODE_OFF) begin
        mode_written_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  AST_ACK_NEXT: assert property (req |=> o_wb_ack)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_SWITCH_BOUND: assert property (
    $rose(o_switch_pending) |-> ##[1:65] !o_switch_pending)
    else $error("clock switch not done within 64 cycles");
  AST_HELD_NO_TICK: assert property (
    !o_cpu_run [*3] |-> !o_cpu_tick)
    else $error("machine cycle tick while CPU held");
  AST_ONE_MODE: assert property (
    $onehot0({o_cpu_run, o_halt, o_stop}))
    else $error("more than one operating mode");
  AST_TICK_SPACING: assert property (
    o_cpu_tick |=> !o_cpu_tick [*3])
    else $error("ticks closer than four cycles");
  AST_TICK_ON_CLOCK: assert property (
    o_cpu_tick |-> o_cpu_clock ##1 !o_cpu_clock)
    else $error("machine cycle tick off the CPU clock edge");
  AST_STOP_ENTRY: assert property (
    req && i_wb_we && i_wb_sel[0] && i_wb_adr == CPU_CLOCK_CONTROL_OFF
    && i_wb_dat[3:0] == 4'h8 && o_cpu_run |-> ##[1:2] o_stop)
    else $error("stop write did not stop the CPU");
  AST_STOP_PIN_LOW: assert property (
    o_stop [*4] |-> !o_clock_output_pin)
    else $error("clock output active in stop");
  AST_PIN_IDLE: assert property (
    !mode_written_reg |-> !o_clock_output_pin)
    else $error("clock output active before any mode write");
  AST_MODE_UNREADABLE: assert property (
    o_wb_ack && mode_read_reg |-> o_wb_dat == '0)
    else $error("output mode register read back nonzero");
endmodule : cpu_clock_gen_assertions

bind cpu_clock_gen cpu_clock_gen_assertions u_cpu_clock_gen_assertions (
  .i_clock, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_cpu_tick, .o_cpu_clock,
  .o_cpu_run, .o_halt, .o_stop, .o_switch_pending, .o_clock_output_pin
);
`default_nettype wire

// *** tb/cpu_clock_switch_and_clock_output_bench.sv ***
// Self-checking bench for the CPU clock switch and clock output
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_switch_and_clock_output_bench;
  import clock_gen_pkg::*;

  localparam int TRIM = 10;

  logic             clock = 1'b0;
  logic             arst_n = 1'b0;
  logic             wb_cyc = 1'b0;
  logic             wb_stb = 1'b0;
  logic             wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [SEL_W-1:0] wb_sel = '0;
  logic [DAT_W-1:0] wb_wdat = '0;
  logic [DAT_W-1:0] wb_rdat;
  logic [DAT_W-1:0] rdat_q;
  logic             wb_ack;
  logic             wait_option = 1'b0;
  logic             release_evt = 1'b0;
  logic             rx_clear = 1'b0;
  logic             cpu_tick, cpu_run, halt, stop, pending, pin;
  int               pend_cnt = 0;
  int               pend0;
  logic [7:0]       min_high, min_low;
  logic [15:0]      edges;
  int               failures = 0;
  int               samples_checked = 0;
  int               n;
  int               div_tab[4] = '{64, 16, 8, 4};
  int               half_tab[4] = '{32, 4, 2, 1};

  cpu_clock_gen #(.WAIT_EXP_TRIM(TRIM)) u_cpu_clock_gen (
    .i_clock(clock), .i_arst_n(arst_n), .i_wb_cyc(wb_cyc),
    .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
    .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat),
    .o_wb_ack(wb_ack), .i_wait_option(wait_option),
    .i_standby_release(release_evt), .o_cpu_tick(cpu_tick),
    .o_cpu_clock(), .o_cpu_run(cpu_run), .o_halt(halt), .o_stop(stop),
    .o_switch_pending(pending), .o_clock_output_pin(pin)
  );

  carrier_receiver u_carrier_receiver (
    .i_clock(clock), .i_arst_n(arst_n), .i_clear(rx_clear), .i_pin(pin),
    .o_min_high(min_high), .o_min_low(min_low), .o_edges(edges)
  );

  initial begin
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    if (pending === 1'b1) pend_cnt <= pend_cnt + 1;
  end

  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_rng

  // One classic Wishbone cycle; ack is due exactly two edges on
  task automatic bus(input logic we, input logic [ADR_W-1:0] adr,
                     input logic [3:0] dat, input logic [SEL_W-1:0] sel);
    int k;
    k = 0;
    @(posedge clock);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= sel;
    wb_wdat <= {28'h000_0000, dat};
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    rdat_q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    check_rng(k, 2, 2);
  endtask : bus

  task automatic rd_chk(input logic [ADR_W-1:0] adr, input logic [3:0] exp);
    bus(1'b0, adr, 4'h0, 4'h1);
    check_val(rdat_q, {28'h000_0000, exp});
  endtask : rd_chk

  task automatic wait_run(input int lo);
    int k;
    k = 0;
    while (cpu_run !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    check_rng(k, lo, lo + 6);
  endtask : wait_run

  task automatic tick_gap(input int exp);
    int k;
    k = 0;
    while (cpu_tick !== 1'b1) @(negedge clock);
    do begin
      @(negedge clock);
      k++;
    end while (cpu_tick !== 1'b1 && k < 100);
    check_rng(k, exp, exp);
  endtask : tick_gap

  task automatic do_reset(input logic opt);
    @(posedge clock);
    wait_option <= opt;
    arst_n      <= 1'b0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
  endtask : do_reset

  task automatic pulse_release();
    @(posedge clock);
    release_evt <= 1'b1;
    @(posedge clock);
    release_evt <= 1'b0;
  endtask : pulse_release

  task automatic rx_reset();
    @(posedge clock);
    rx_clear <= 1'b1;
    @(posedge clock);
    rx_clear <= 1'b0;
  endtask : rx_reset

  initial begin
    do_reset(1'b0);
    wait_run(2 ** (RESET_EXP_LONG - TRIM));
    rd_chk(CPU_CLOCK_CONTROL_OFF, 4'h0);
    rd_chk(CLOCK_STATUS_OFF, 4'h2);
    bus(1'b1, 4'h2, 4'hf, 4'h1);
    rd_chk(4'h2, 4'h0);
    // Every select code, then back to the slowest
    for (int c = 0; c < 5; c++) begin
      pend0 = pend_cnt;
      bus(1'b1, CPU_CLOCK_CONTROL_OFF, 4'(c % 4), 4'h1);
      n = 0;
      while (pending !== 1'b0 && n < 100) begin
        @(negedge clock);
        n++;
      end
      check_rng(n, 0, 64);
      check_val(32'(pend_cnt != pend0), 32'(c != 0));
      tick_gap(div_tab[c % 4]);
      rd_chk(CPU_CLOCK_CONTROL_OFF, 4'(c % 4));
      rd_chk(CLOCK_STATUS_OFF, 4'(((c % 4) << 2) | 2));
    end
    // Each carrier source keyed on and off twice
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, CLOCK_OUTPUT_MODE_OFF, 4'(s), 4'h1);
      rx_reset();
      repeat (2) begin
        bus(1'b1, CLOCK_OUTPUT_MODE_OFF, 4'(8 + s), 4'h1);
        rd_chk(CLOCK_OUTPUT_MODE_OFF, 4'h0);
        repeat (300) @(negedge clock);
        bus(1'b1, CLOCK_OUTPUT_MODE_OFF, 4'(s), 4'h1);
        repeat (37) @(negedge clock);
      end
      check_val(32'(min_high), 32'(half_tab[s]));
      check_val(32'(min_low), 32'(half_tab[s]));
    end
    rx_reset();
    bus(1'b1, CLOCK_OUTPUT_MODE_OFF, 4'h8, 4'h0);
    repeat (100) @(negedge clock);
    check_val(32'(edges), 32'h0000_0000);
    // Stop and wake with the shortest and longest waits
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, INTERVAL_TIMER_MODE_OFF, k ? 4'h0 : 4'h7, 4'h1);
      bus(1'b1, CPU_CLOCK_CONTROL_OFF, 4'h8, 4'h1);
      repeat (8) @(negedge clock);
      check_val(32'(stop), 32'h0000_0001);
      pulse_release();
      wait_run(2 ** ((k ? STOP_EXP_000 : STOP_EXP_111) - TRIM));
    end
    // Halt wakes straight back to run, no wait
    bus(1'b1, CPU_CLOCK_CONTROL_OFF, 4'h4, 4'h1);
    repeat (4) @(negedge clock);
    check_val(32'({halt, cpu_run}), 32'h0000_0002);
    pulse_release();
    wait_run(2);
    rd_chk(CPU_CLOCK_CONTROL_OFF, 4'h0);
    do_reset(1'b1);
    wait_run(2 ** (RESET_EXP_SHORT - TRIM));
    rd_chk(CLOCK_STATUS_OFF, 4'h2);
    print_verdict();
  end

  initial begin
    #200_000;
    failures++;
    print_verdict();
  end
endmodule : cpu_clock_switch_and_clock_output_bench
`default_nettype wire
